// ### src/dpsc_pkg.sv
package dpsc_pkg;

  localparam int DATA_W = 9;
  localparam int ADDR_W = 11;
  localparam int CNT_W = 4;
  localparam int CLK_NS = 10;
  localparam int SYNC_STAGES = 2;

  // Slowest speed grade, so any fitted part is met
  localparam int T_AA_NS = 55;
  localparam int T_ACE_NS = 55;
  localparam int T_AOE_NS = 35;
  localparam int T_HZ_NS = 30;
  localparam int T_BDD_NS = 45;
  localparam int T_WP_NS = 40;
  localparam int T_EW_NS = 40;
  localparam int T_AW_NS = 40;
  localparam int T_DW_NS = 20;
  localparam int T_WZ_NS = 30;
  localparam int T_WH_NS = 20;
  localparam int T_WR_NS = 0;
  localparam int WRITE_DATA_HOLD_NS = 0;

  function automatic int dpsc_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : dpsc_max

  // Least times round up, never below one cycle
  function automatic int dpsc_cyc(input int ns);
    return dpsc_max(1, (ns + CLK_NS - 1) / CLK_NS);
  endfunction : dpsc_cyc

  localparam logic [CNT_W-1:0] RD_ACC_CYC =
    CNT_W'(dpsc_cyc(dpsc_max(T_AA_NS, dpsc_max(T_ACE_NS, T_AOE_NS))) + SYNC_STAGES);
  localparam logic [CNT_W-1:0] RD_BDD_CYC = CNT_W'(dpsc_cyc(T_BDD_NS) + SYNC_STAGES);
  localparam logic [CNT_W-1:0] TURN_CYC = CNT_W'(dpsc_cyc(T_HZ_NS));
  localparam logic [CNT_W-1:0] WR_PULSE_CYC =
    CNT_W'(dpsc_cyc(dpsc_max(dpsc_max(T_WP_NS, T_EW_NS), dpsc_max(T_AW_NS, T_WZ_NS + T_DW_NS))));
  localparam logic [CNT_W-1:0] WR_BUSY_HOLD_CYC = CNT_W'(dpsc_cyc(T_WH_NS));
  localparam logic [CNT_W-1:0] WR_DATA_HOLD_CYC = CNT_W'(dpsc_cyc(dpsc_max(WRITE_DATA_HOLD_NS, T_WR_NS)));

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WR_ADDR = 3'h1,
    ST_WR_PULSE = 3'h3,
    ST_WR_HOLD = 3'h2,
    ST_RD_WAIT = 3'h4,
    ST_TURN = 3'h5
  } dpsc_state_t;

  typedef struct packed {
    dpsc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic ceN;
    logic oeN;
    logic rwN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dataOut;
    logic dataOeN;
    logic reqReady;
    logic rspValid;
    logic [DATA_W-1:0] rspData;
  } dpsc_regs_t;

  localparam dpsc_regs_t REGS_RESET = '{
    state: ST_IDLE, cnt: '0, ceN: 1'b1, oeN: 1'b1, rwN: 1'b1, addr: '0,
    dataOut: '0, dataOeN: 1'b1, reqReady: 1'b0, rspValid: 1'b0, rspData: '0
  };

  typedef struct packed {
    logic [DATA_W-1:0] dataMeta;
    logic busyMetaN;
    logic [DATA_W-1:0] dataIn;
    logic busyN;
  } dpsc_sync_t;

  localparam dpsc_sync_t SYNC_RESET = '{dataMeta: '0, busyMetaN: 1'b1, dataIn: '0, busyN: 1'b1};

endpackage : dpsc_pkg

// ### src/dpsc_sync_if.sv
`timescale 1ns/100ps
interface dpsc_sync_if;
  import dpsc_pkg::*;
  logic [DATA_W-1:0] dataIn;
  logic busyN;
  modport source (output dataIn, output busyN);
  modport sink (input dataIn, input busyN);
endinterface : dpsc_sync_if

// ### src/dpsc_sync.sv
`timescale 1ns/100ps
module dpsc_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [dpsc_pkg::DATA_W-1:0] pinData,
  input wire logic pinBusyN,
  dpsc_sync_if.source syncOut
);
  import dpsc_pkg::*;

  dpsc_sync_t regs;
  dpsc_sync_t next_regs;

  // First stage feeds only the second stage
  always_comb begin
    next_regs.dataMeta = pinData;
    next_regs.busyMetaN = pinBusyN;
    next_regs.dataIn = regs.dataMeta;
    next_regs.busyN = regs.busyMetaN;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regs <= SYNC_RESET;
    end else begin
      regs <= next_regs;
    end
  end

  assign syncOut.dataIn = regs.dataIn;
  assign syncOut.busyN = regs.busyN;
endmodule : dpsc_sync

// ### src/dpsc_ctrl.sv
`timescale 1ns/100ps
module dpsc_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [dpsc_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [dpsc_pkg::DATA_W-1:0] reqData,
  output logic reqReady,
  output logic rspValid,
  output logic [dpsc_pkg::DATA_W-1:0] rspData,
  output logic ramCeN,
  output logic ramOeN,
  output logic ramRwN,
  output logic [dpsc_pkg::ADDR_W-1:0] ramAddr,
  input wire logic [dpsc_pkg::DATA_W-1:0] ramDataIn,
  output logic [dpsc_pkg::DATA_W-1:0] ramDataOut,
  output logic ramDataOeN,
  input wire logic ramBusyN
);
  import dpsc_pkg::*;

  dpsc_regs_t regs;
  dpsc_regs_t next_regs;

  // Every timed state counts down to one, then acts on the next edge
  function automatic logic dpsc_expired(input logic [CNT_W-1:0] cnt);
    return (cnt <= 4'h1);
  endfunction : dpsc_expired

  function automatic logic [CNT_W-1:0] dpsc_step(input logic [CNT_W-1:0] cnt);
    return dpsc_expired(cnt) ? cnt : cnt - 4'h1;
  endfunction : dpsc_step

  // Busy only ever lengthens a wait; a longer remainder is kept
  function automatic logic [CNT_W-1:0] dpsc_stretch(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] least);
    return (cnt > least) ? cnt : least;
  endfunction : dpsc_stretch

  dpsc_sync_if syncBus ();

  dpsc_sync u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .pinData(ramDataIn),
    .pinBusyN(ramBusyN),
    .syncOut(syncBus.source)
  );

  always_comb begin
    next_regs = regs;
    next_regs.rspValid = 1'b0;
    case (regs.state)
      ST_IDLE: begin
        if (reqValid && regs.reqReady) begin
          // Address moves while select and strobe are high
          next_regs.addr = reqAddr;
          if (reqWrite) begin
            next_regs.dataOut = reqData;
            // Bus is free: the turnaround after reads has already passed
            next_regs.dataOeN = 1'b0;
            next_regs.state = ST_WR_ADDR;
          end else begin
            // Address valid together with select falling, strobe high
            next_regs.ceN = 1'b0;
            next_regs.oeN = 1'b0;
            next_regs.cnt = RD_ACC_CYC;
            next_regs.state = ST_RD_WAIT;
          end
        end
      end
      ST_WR_ADDR: begin
        // Select and strobe fall together so the device never drives
        next_regs.ceN = 1'b0;
        next_regs.rwN = 1'b0;
        next_regs.cnt = WR_PULSE_CYC;
        next_regs.state = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        // Busy seen two cycles late; the reload covers the write hold after it
        if (!syncBus.busyN) begin
          next_regs.cnt = dpsc_stretch(regs.cnt, WR_BUSY_HOLD_CYC);
        end else if (!dpsc_expired(regs.cnt)) begin
          next_regs.cnt = dpsc_step(regs.cnt);
        end else begin
          next_regs.ceN = 1'b1;
          next_regs.rwN = 1'b1;
          next_regs.cnt = WR_DATA_HOLD_CYC;
          next_regs.state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        // Data held one full cycle past the end of write
        if (!dpsc_expired(regs.cnt)) begin
          next_regs.cnt = dpsc_step(regs.cnt);
        end else begin
          next_regs.dataOeN = 1'b1;
          next_regs.state = ST_IDLE;
        end
      end
      ST_RD_WAIT: begin
        // Count includes the input synchroniser stages
        if (!syncBus.busyN) begin
          next_regs.cnt = dpsc_stretch(regs.cnt, RD_BDD_CYC);
        end else if (!dpsc_expired(regs.cnt)) begin
          next_regs.cnt = dpsc_step(regs.cnt);
        end else begin
          next_regs.rspData = syncBus.dataIn;
          next_regs.rspValid = 1'b1;
          next_regs.ceN = 1'b1;
          next_regs.oeN = 1'b1;
          next_regs.cnt = TURN_CYC;
          next_regs.state = ST_TURN;
        end
      end
      ST_TURN: begin
        // Device outputs may take the high-impedance time to let go
        if (!dpsc_expired(regs.cnt)) begin
          next_regs.cnt = dpsc_step(regs.cnt);
        end else begin
          next_regs.state = ST_IDLE;
        end
      end
      default: begin
        next_regs = REGS_RESET;
      end
    endcase
    next_regs.reqReady = (next_regs.state == ST_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regs <= REGS_RESET;
    end else begin
      regs <= next_regs;
    end
  end

  assign reqReady = regs.reqReady;
  assign rspValid = regs.rspValid;
  assign rspData = regs.rspData;
  assign ramCeN = regs.ceN;
  assign ramOeN = regs.oeN;
  assign ramRwN = regs.rwN;
  assign ramAddr = regs.addr;
  assign ramDataOut = regs.dataOut;
  assign ramDataOeN = regs.dataOeN;
endmodule : dpsc_ctrl

// ### test/dpsc_ctrl_monitor.sv
`timescale 1ns/100ps
module dpsc_ctrl_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic ramCeN,
  input wire logic ramOeN,
  input wire logic ramRwN,
  input wire logic [10:0] ramAddr,
  input wire logic [8:0] ramDataOut,
  input wire logic ramDataOeN
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence rdHold;
    (!ramOeN && !ramCeN && ramRwN)[*8];
  endsequence
  sequence wrPulse;
    (!ramRwN && !ramCeN && ramOeN && !ramDataOeN)[*4];
  endsequence
  chk_addr_stable: assert property ((!ramCeN && !ramRwN) |=> $stable(ramAddr))
    else $error("address moved in write");
  chk_write_pulse: assert property ($fell(ramRwN) |-> $fell(ramCeN) ##0 wrPulse)
    else $error("write pulse short");
  chk_write_end: assert property ($rose(ramRwN) |-> $rose(ramCeN) && !ramDataOeN && $stable(ramDataOut))
    else $error("write data not held");
  chk_read_hold: assert property ($fell(ramOeN) |-> rdHold ##1 (rspValid && ramCeN && ramOeN))
    else $error("read timing wrong");
  chk_rsp_pulse: assert property (rspValid |=> !rspValid)
    else $error("response too long");
  chk_turn_gap: assert property ($rose(ramOeN) |-> ramDataOeN[*3])
    else $error("drive too soon after read");
  chk_no_clash: assert property (!ramDataOeN |-> ramOeN)
    else $error("drive while outputs on");
  chk_ready_idle: assert property (reqReady |-> ramCeN && ramOeN && ramRwN && ramDataOeN)
    else $error("ready while busy");
endmodule : dpsc_ctrl_monitor
bind dpsc_ctrl dpsc_ctrl_monitor u_mon (.sys_clk(sys_clk), .reset(reset), .reqReady(reqReady), .rspValid(rspValid),
  .ramCeN(ramCeN), .ramOeN(ramOeN), .ramRwN(ramRwN), .ramAddr(ramAddr), .ramDataOut(ramDataOut),
  .ramDataOeN(ramDataOeN));

// ### test/dpsc_sram_model.sv
`timescale 1ns/100ps
module dpsc_sram_model #(parameter int ACC_NS = 55, parameter int WH_NS = 20) (
  input wire logic sys_clk,
  input wire logic ramCeN,
  input wire logic ramOeN,
  input wire logic ramRwN,
  input wire logic [10:0] ramAddr,
  input wire logic [8:0] ramDataOut,
  input wire logic ramDataOeN,
  input wire logic ramBusyN,
  output logic [8:0] busData
);
  logic [8:0] mem [0:2047];
  logic [8:0] floatVal = 9'h0aa;
  logic [10:0] wrAddr;
  logic drv = 1'b0;
  logic inWr = 1'b0;
  time busyRise = 0;
  // A write ending too soon after busy lets go is lost
  always @(posedge ramBusyN) busyRise = $time;
  // Floating pins change every cycle so stale data never reads as valid
  always @(posedge sys_clk) floatVal <= ~floatVal;
  always begin
    @(negedge ramOeN);
    #(ACC_NS);
    drv = !ramOeN && !ramCeN && ramRwN;
  end
  always @(posedge ramOeN or posedge ramCeN or negedge ramRwN) drv = 1'b0;
  always @(ramCeN or ramRwN) begin
    if (!ramCeN && !ramRwN) begin
      inWr = 1'b1;
      wrAddr = ramAddr;
    end else if (inWr) begin
      inWr = 1'b0;
      if (ramBusyN && ($time - busyRise) >= WH_NS) mem[wrAddr] = busData;
    end
  end
  assign busData = !ramDataOeN ? ramDataOut : drv ? mem[ramAddr] : floatVal;
endmodule : dpsc_sram_model

// ### test/dpsc_ctrl_tb.sv
`timescale 1ns/100ps
module dpsc_ctrl_tb;
  import dpsc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [ADDR_W-1:0] reqAddr = '0;
  logic [DATA_W-1:0] reqData = '0;
  logic ramBusyN = 1'b1;
  logic reqReady, rspValid, ramCeN, ramOeN, ramRwN, ramDataOeN;
  logic [ADDR_W-1:0] ramAddr;
  logic [DATA_W-1:0] rspData, ramDataOut, busData;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  initial forever #5 sys_clk = ~sys_clk;
  dpsc_ctrl DUT (.sys_clk(sys_clk), .reset(reset), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .ramCeN(ramCeN), .ramOeN(ramOeN),
    .ramRwN(ramRwN), .ramAddr(ramAddr), .ramDataIn(busData), .ramDataOut(ramDataOut), .ramDataOeN(ramDataOeN),
    .ramBusyN(ramBusyN));
  dpsc_sram_model u_ram (.sys_clk(sys_clk), .ramCeN(ramCeN), .ramOeN(ramOeN), .ramRwN(ramRwN), .ramAddr(ramAddr),
    .ramDataOut(ramDataOut), .ramDataOeN(ramDataOeN), .ramBusyN(ramBusyN), .busData(busData));
  task automatic wrap_up;
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic cmp(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp
  // One request; a read compares its answer with d
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqData = d;
    // Ready looked at off the edge, so the taking edge never reads as a refusal
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    cmp(9'h001, {8'h00, reqReady});
    @(posedge sys_clk);
    @(negedge sys_clk);
    reqValid = 1'b0;
    n = 0;
    while (!wr && rspValid !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    if (!wr) cmp(d, (n < 20) ? rspData : ~d);
  endtask : access
  task automatic test_idle;
    cmp(9'h00f, {5'h00, ramCeN, ramOeN, ramRwN, ramDataOeN});
    $display("test_idle done");
  endtask : test_idle
  task automatic test_write_read;
    logic [ADDR_W-1:0] at [4] = '{11'h000, 11'h7ff, 11'h155, 11'h2aa};
    logic [DATA_W-1:0] dt [4] = '{9'h1ff, 9'h000, 9'h0aa, 9'h155};
    for (int i = 0; i < 4; i++) access(1'b1, at[i], dt[i]);
    for (int i = 3; i >= 0; i--) access(1'b0, at[i], dt[i]);
    access(1'b1, at[2], 9'h0f0);
    access(1'b0, at[2], 9'h0f0);
    $display("test_write_read done");
  endtask : test_write_read
  // Contention on the far port must stretch the strobe, or the cell keeps old data
  task automatic test_busy_write;
    fork
      access(1'b1, 11'h3c3, 9'h123);
      begin
        repeat (3) @(negedge sys_clk);
        ramBusyN = 1'b0;
        // Busy outlasts an unstretched pulse, so only the stretch saves the word
        repeat (8) @(negedge sys_clk);
        ramBusyN = 1'b1;
      end
    join
    access(1'b0, 11'h3c3, 9'h123);
    $display("test_busy_write done");
  endtask : test_busy_write
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    test_idle();
    test_write_read();
    test_busy_write();
    wrap_up();
  end
endmodule : dpsc_ctrl_tb
